// ===== pcm_pkg.sv
// Package for the power and clock management block
package pcm_pkg;
   // ----------------------------------------------------------------
   // Register map (word offsets are byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] PCM_ADDR_CLOCK_DIVIDER_REGISTER = 8'h00;
   localparam logic [7:0] PCM_ADDR_GATE = 8'h04;
   localparam logic [7:0] PCM_ADDR_CFG = 8'h08;
   localparam logic [7:0] PCM_ADDR_STATUS = 8'h0C;
   localparam logic [7:0] PCM_ADDR_PSAVE = 8'h10;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int PCM_ROI_BIT = 15;
   localparam int PCM_RATIO_HI = 14;
   localparam int PCM_RATIO_LO = 12;
   localparam int PCM_CPU_SLOWDOWN_ENABLE_BIT = 11;
   localparam int PCM_CFG_FSM_BIT = 0;
   localparam int PCM_CFG_WDT_BIT = 1;
   localparam int PCM_NMOD = 8;
   localparam logic [15:0] PCM_DIV_RESET = 16'h0000;
   localparam logic [PCM_NMOD-1:0] PCM_GATE_RESET = 8'h00;
   // Arbitrary value: which peripherals exist on this variant
   localparam logic [PCM_NMOD-1:0] PCM_PRESENT = 8'h7F;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int PCM_CLK_MHZ = 40;
   // Reference clock edges (rising or falling) with no system clock activity = failure
   localparam logic [3:0] PCM_FAIL_REFS = 4'h4;
   // Gate delay: one instruction cycle
   localparam logic [1:0] PCM_GATE_DLY = 2'h1;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      PCM_RUN = 4'h1,
      PCM_ENTER = 4'h2,
      PCM_SLEEP = 4'h4,
      PCM_IDLE = 4'h8
   } pcm_state_type;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } pcm_wb_req_type;
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } pcm_wb_rsp_type;
endpackage

// ===== pcm_top.sv
// Power and clock management: fail-safe, sleep, idle, doze, gating
//
// The implementer's own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module pcm_top
   import pcm_pkg::*;
(
   input wire logic clk, // System clock, 40 MHz
   input wire logic arst_n, // Asynchronous reset, active low
   input wire pcm_wb_req_type wb_req, // Wishbone request
   output pcm_wb_rsp_type wb_rsp, // Wishbone answer
   input wire logic save_exec, // CPU executes power-save instruction
   input wire logic save_idle, // Operand: 1 idle, 0 sleep
   input wire logic irq_pending, // Any individually enabled interrupt
   input wire logic wdt_timeout, // Watchdog time-out
   input wire logic low_power_rc_oscillator_ref, // Low-power RC reference clock, async
   input wire logic sysclk_alive, // Toggles while system osc runs, async
   input wire logic pll_in_use, // PLL scales system clock now
   output logic cpu_clk_en, // CPU clock enable
   output logic periph_clk_en, // System-clocked peripherals enable
   output logic [PCM_NMOD-1:0] mod_clk_en, // Per-module enables
   output logic sysosc_on, // System oscillator source enabled
   output logic low_power_rc_oscillator_on, // Low-power RC oscillator enabled
   output logic wdt_clear, // Watchdog count clear pulse
   output logic clk_fail_trap, // Clock failure trap, sticky level
   output logic fallback_frc, // Run from fast internal oscillator
   output logic fallback_pll // Route fast RC through PLL
);
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [15:0] div_q, div_d;
   logic [PCM_NMOD-1:0] gate_q, gate_d;
   logic [1:0] cfg_q, cfg_d;
   logic ack_q;
   logic [31:0] rdat_q, rdat_d;
   pcm_state_type st_q, st_d;
   logic fail_q, fail_d, pll_keep_q, pll_keep_d;
   logic [6:0] dz_cnt_q, dz_cnt_d;
   logic doze_q, doze_d, wdclr_q, wdclr_d;
   logic [PCM_NMOD-1:0] gate_eff_q;
   logic [1:0] gdly_q;
   logic [PCM_NMOD-1:0] gate_pend_q;
   logic [2:0] ref_s_q, alv_s_q;
   logic [3:0] miss_q, miss_d;
   logic seen_q, seen_d;
   // All checks share the system clock and drop out during reset
   default clocking @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire req = wb_req.cyc & wb_req.stb & ~ack_q;
   // Writes land at the edge where the master sees ack, not earlier
   wire wr = wb_req.cyc & wb_req.stb & wb_req.we & ack_q;
   wire hit_div = wb_req.adr == PCM_ADDR_CLOCK_DIVIDER_REGISTER;
   wire hit_gate = wb_req.adr == PCM_ADDR_GATE;
   wire hit_cfg = wb_req.adr == PCM_ADDR_CFG;
   wire hit_st = wb_req.adr == PCM_ADDR_STATUS;
   wire hit_ps = wb_req.adr == PCM_ADDR_PSAVE;
   wire fsm_en = cfg_q[PCM_CFG_FSM_BIT];
   wire wdt_en = cfg_q[PCM_CFG_WDT_BIT];
   wire [2:0] ratio = div_q[PCM_RATIO_HI:PCM_RATIO_LO];
   wire wake = irq_pending | wdt_timeout;
   wire in_sleep = st_q == PCM_SLEEP;
   wire in_idle = st_q == PCM_IDLE;
   wire [31:0] status_w = {24'h000000, 1'b0, pll_keep_q, fail_q,
                           doze_q, st_q};
   always_comb begin
      div_d = div_q;
      gate_d = gate_q;
      cfg_d = cfg_q;
      rdat_d = 32'h00000000;
      if (wr && hit_div && wb_req.sel[0])
         div_d[7:0] = wb_req.dat[7:0];
      if (wr && hit_div && wb_req.sel[1])
         div_d[15:8] = wb_req.dat[15:8];
      if (wr && hit_gate && wb_req.sel[0])
         gate_d = wb_req.dat[PCM_NMOD-1:0];
      if (wr && hit_cfg && wb_req.sel[0])
         cfg_d = wb_req.dat[1:0];
      if (hit_div)
         rdat_d = {16'h0000, div_q};
      else if (hit_gate)
         rdat_d = {24'h000000, gate_q};
      else if (hit_cfg)
         rdat_d = {30'h00000000, cfg_q};
      else if (hit_st)
         rdat_d = status_w;
   end
   // Unmapped addresses ack with zero data, writes dropped
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h00000000;
         div_q <= PCM_DIV_RESET;
         gate_q <= PCM_GATE_RESET;
         cfg_q <= 2'h0;
      end else begin
         ack_q <= req;
         rdat_q <= rdat_d;
         div_q <= div_d;
         gate_q <= gate_d;
         cfg_q <= cfg_d;
      end
   end
   assign wb_rsp.ack = ack_q;
   assign wb_rsp.dat = rdat_q;
   // ----------------------------------------------------------------
   // Power-save state machine
   // ----------------------------------------------------------------
   // A bus write to the power-save word also issues the instruction.
   wire ps_wr = wr & hit_ps;
   wire ps_go = save_exec | ps_wr;
   wire ps_idle = save_exec ? save_idle : wb_req.dat[0];
   logic ent_idle_q;
   always_comb begin
      st_d = st_q;
      wdclr_d = 1'b0;
      case (st_q)
         PCM_RUN: begin
            if (ps_go)
               st_d = PCM_ENTER;
         end
         PCM_ENTER: begin
            // Interrupts are ignored here, entry always completes
            wdclr_d = 1'b1;
            st_d = ent_idle_q ? PCM_IDLE : PCM_SLEEP;
         end
         PCM_SLEEP: begin
            if (wake)
               st_d = PCM_RUN;
         end
         PCM_IDLE: begin
            if (wake)
               st_d = PCM_RUN;
         end
         default: st_d = PCM_RUN;
      endcase
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= PCM_RUN;
         ent_idle_q <= 1'b0;
         wdclr_q <= 1'b0;
      end else begin
         st_q <= st_d;
         if (st_q == PCM_RUN && ps_go)
            ent_idle_q <= ps_idle;
         wdclr_q <= wdclr_d;
      end
   end
   assign wdt_clear = wdclr_q;
   // Sleep stops the source; the clock select is untouched, so wake
   // resumes the same source.
   assign sysosc_on = !in_sleep;
   assign periph_clk_en = !in_sleep;
   assign low_power_rc_oscillator_on = in_sleep ? wdt_en : (fsm_en | wdt_en);
   // ----------------------------------------------------------------
   // Doze divider
   // ----------------------------------------------------------------
   // Counter runs on the peripheral clock so each slow CPU tick lands
   // on a peripheral edge; a ratio change keeps the count, which wraps at the new limit.
   wire [6:0] dz_max = 7'((8'h01 << ratio) - 8'h01);
   always_comb begin
      doze_d = div_q[PCM_CPU_SLOWDOWN_ENABLE_BIT];
      if (div_q[PCM_ROI_BIT] && irq_pending)
         doze_d = 1'b0;
      dz_cnt_d = 7'h00;
      if (doze_q && dz_cnt_q < dz_max)
         dz_cnt_d = dz_cnt_q + 7'h01;
   end
   // RETURN_ON_INTERRUPT_BIT forces full speed only while irq_pending is high; the doze bit stays set, so dozing resumes after the ISR
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         doze_q <= 1'b0;
         dz_cnt_q <= 7'h00;
      end else begin
         doze_q <= doze_d;
         dz_cnt_q <= dz_cnt_d;
      end
   end
   wire dz_tick = !doze_q || dz_cnt_q == 7'h00;
   assign cpu_clk_en = (st_q == PCM_RUN) && dz_tick;
   // ----------------------------------------------------------------
   // Module gates
   // ----------------------------------------------------------------
   // One instruction cycle of delay before a gate change acts.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gate_eff_q <= PCM_GATE_RESET;
         gate_pend_q <= PCM_GATE_RESET;
         gdly_q <= 2'h0;
      end else begin
         gate_pend_q <= gate_q;
         if (gate_pend_q != gate_q)
            gdly_q <= PCM_GATE_DLY;
         else if (gdly_q != 2'h0)
            gdly_q <= gdly_q - 2'h1;
         else
            gate_eff_q <= gate_pend_q;
      end
   end
   genvar gi;
   generate
      for (gi = 0; gi < PCM_NMOD; gi++) begin : g_mod
         // Gated module loses its clock; its register port stays open
         assign mod_clk_en[gi] = PCM_PRESENT[gi] & ~gate_eff_q[gi] &
                                 ~in_sleep;
      end
   endgenerate
   // ----------------------------------------------------------------
   // Fail-safe monitor
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ref_s_q <= 3'h0;
         alv_s_q <= 3'h0;
      end else begin
         ref_s_q <= {ref_s_q[1:0], low_power_rc_oscillator_ref};
         alv_s_q <= {alv_s_q[1:0], sysclk_alive};
      end
   end
   wire ref_edge = ref_s_q[2] ^ ref_s_q[1];
   wire alv_edge = alv_s_q[2] ^ alv_s_q[1];
   wire mon_on = fsm_en & ~in_sleep;
   always_comb begin
      miss_d = miss_q;
      seen_d = seen_q | alv_edge;
      fail_d = fail_q;
      pll_keep_d = pll_keep_q;
      if (!mon_on) begin
         miss_d = 4'h0;
         seen_d = 1'b0;
      end else if (ref_edge) begin
         seen_d = alv_edge;
         miss_d = seen_q ? 4'h0 : miss_q + 4'h1;
         if (!seen_q && miss_q + 4'h1 >= PCM_FAIL_REFS && !fail_q) begin
            fail_d = 1'b1;
            pll_keep_d = pll_in_use;
         end
      end
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         miss_q <= 4'h0;
         seen_q <= 1'b0;
         fail_q <= 1'b0;
         pll_keep_q <= 1'b0;
      end else begin
         miss_q <= miss_d;
         seen_q <= seen_d;
         fail_q <= fail_d;
         pll_keep_q <= pll_keep_d;
      end
   end
   assign clk_fail_trap = fail_q;
   assign fallback_frc = fail_q;
   assign fallback_pll = fail_q & pll_keep_q;
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_sleep_wdclr: assert property ($rose(in_sleep) |-> wdt_clear)
      else $error("watchdog not cleared on sleep entry");
   a_sleep_osc_off: assert property (
      in_sleep |-> !sysosc_on && !periph_clk_en && !cpu_clk_en)
      else $error("clock running in sleep");
   a_sleep_low_power_rc_oscillator: assert property (in_sleep |-> low_power_rc_oscillator_on == wdt_en)
      else $error("rc state wrong in sleep");
   a_idle_low_power_rc_oscillator: assert property (
      in_idle && (fsm_en || wdt_en) |-> low_power_rc_oscillator_on)
      else $error("rc off in idle");
   a_enter_two: assert property (
      st_q == PCM_RUN && ps_go |=> st_q == PCM_ENTER ##1
      (in_sleep || in_idle))
      else $error("entry not completed");
   a_wake_run: assert property (
      (in_sleep || in_idle) && wake |=> st_q == PCM_RUN)
      else $error("no wake");
   a_doze_full: assert property (
      !doze_q && st_q == PCM_RUN |-> cpu_clk_en)
      else $error("cpu slowed without doze");
   a_gate_delay: assert property (
      $changed(gate_q) |=> ##1 $stable(gate_eff_q))
      else $error("gate acted too early");
   a_fail_sleep: assert property (in_sleep |=> miss_q == 4'h0)
      else $error("monitor active in sleep");
   a_fail_pll: assert property (
      $rose(fail_q) |-> pll_keep_q == $past(pll_in_use))
      else $error("pll factor not kept");
   a_fail_sticky: assert property (fail_q |=> fail_q)
      else $error("clock failure trap dropped");
   a_run_fsm_rc: assert property (
      !in_sleep && fsm_en |-> low_power_rc_oscillator_on)
      else $error("rc off while monitor enabled");
   a_idle_clocks: assert property (
      in_idle |-> !cpu_clk_en && periph_clk_en && sysosc_on)
      else $error("wrong clocks in idle");
   a_idle_wdclr: assert property ($rose(in_idle) |-> wdt_clear)
      else $error("watchdog not cleared on idle entry");
   a_run_needs_go: assert property (
      st_q == PCM_RUN && !ps_go |=> st_q == PCM_RUN)
      else $error("power save without instruction");
   a_enter_irq_held: assert property (
      st_q == PCM_ENTER && wake |=> in_sleep || in_idle)
      else $error("interrupt cut entry short");
   a_sleep_mods_off: assert property (
      in_sleep |-> mod_clk_en == {PCM_NMOD{1'b0}})
      else $error("module clock on in sleep");
   a_absent_mod_off: assert property (
      (mod_clk_en & ~PCM_PRESENT) == {PCM_NMOD{1'b0}})
      else $error("absent module clocked");
   a_doze_periph: assert property (
      doze_q && !in_sleep |-> periph_clk_en && sysosc_on)
      else $error("doze slowed peripherals");
   a_roi_full: assert property (
      div_q[PCM_ROI_BIT] && irq_pending |=> !doze_q)
      else $error("interrupt left cpu slowed");
   a_doze_tick_gap: assert property (
      doze_q && dz_cnt_q == 7'h00 && ratio != 3'h0 |=>
      !cpu_clk_en || !doze_q)
      else $error("doze tick too soon");
   a_sleep_src_kept: assert property (
      in_sleep |=> $stable(fallback_frc) && $stable(fallback_pll))
      else $error("clock source changed in sleep");
endmodule // pcm_top

// ===== pcm_osc_model.sv
// Behavioural model of the oscillator sources feeding the block
`timescale 1ns/1ps
module pcm_osc_model #(
   parameter int RC_HALF = 110 // RC half period in ns, plain default
) (
   input wire logic clk, // System clock
   input wire logic low_power_rc_oscillator_on, // RC oscillator enable from the block
   input wire logic sysosc_on, // System oscillator enable
   input wire logic osc_dead, // Bench command: oscillator has failed
   output logic low_power_rc_oscillator_ref, // RC reference clock
   output logic sysclk_alive // Toggles while the oscillator runs
);
   initial low_power_rc_oscillator_ref = 1'b0;
   initial sysclk_alive = 1'b0;
   // The RC clock stands still while disabled, as a real one would
   always begin
      #(RC_HALF);
      if (low_power_rc_oscillator_on === 1'b1) low_power_rc_oscillator_ref = ~low_power_rc_oscillator_ref;
   end
   // Activity stops when switched off or failed, so loss is visible
   always @(posedge clk) begin
      if (sysosc_on === 1'b1 && osc_dead !== 1'b1) begin
         sysclk_alive <= ~sysclk_alive;
      end
   end
endmodule // pcm_osc_model

// ===== pcm_top_tb.sv
// Self-checking testbench for the power and clock management block
`timescale 1ns/1ps
module pcm_top_tb
   import pcm_pkg::*;
;
   logic clk, arst_n, save_exec, save_idle, irq_pending, wdt_timeout;
   logic pll_in_use, osc_dead, low_power_rc_oscillator_ref, sysclk_alive, cpu_clk_en;
   logic periph_clk_en, sysosc_on, low_power_rc_oscillator_on, wdt_clear, clk_fail_trap;
   logic fallback_frc, fallback_pll;
   logic [PCM_NMOD-1:0] mod_clk_en;
   logic [31:0] rd;
   pcm_wb_req_type wb_req;
   pcm_wb_rsp_type wb_rsp;
   int error_cnt = 0;
   int check_count = 0;
   int cc, pc, n;
   typedef struct {
      logic [7:0] adr;
      logic [31:0] wd;
      logic [31:0] exp;
   } pcm_row_type;
   pcm_row_type rows [4] = '{
      '{PCM_ADDR_CLOCK_DIVIDER_REGISTER, 32'h0000B800, 32'h0000B800},
      '{PCM_ADDR_GATE, 32'h000000A0, 32'h000000A0},
      '{PCM_ADDR_CFG, 32'h00000003, 32'h00000003},
      '{8'h14, 32'hFFFFFFFF, 32'h00000000}};
   pcm_top i_pcm_top (.clk(clk), .arst_n(arst_n), .wb_req(wb_req),
      .wb_rsp(wb_rsp), .save_exec(save_exec), .save_idle(save_idle),
      .irq_pending(irq_pending), .wdt_timeout(wdt_timeout),
      .low_power_rc_oscillator_ref(low_power_rc_oscillator_ref), .sysclk_alive(sysclk_alive),
      .pll_in_use(pll_in_use), .cpu_clk_en(cpu_clk_en),
      .periph_clk_en(periph_clk_en), .mod_clk_en(mod_clk_en),
      .sysosc_on(sysosc_on), .low_power_rc_oscillator_on(low_power_rc_oscillator_on), .wdt_clear(wdt_clear),
      .clk_fail_trap(clk_fail_trap), .fallback_frc(fallback_frc),
      .fallback_pll(fallback_pll));
   pcm_osc_model i_pcm_osc_model (.clk(clk), .low_power_rc_oscillator_on(low_power_rc_oscillator_on),
      .sysosc_on(sysosc_on), .osc_dead(osc_dead), .low_power_rc_oscillator_ref(low_power_rc_oscillator_ref),
      .sysclk_alive(sysclk_alive));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic conclude;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   // Outputs are read at the edge, before that edge's updates land
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      wb_req <= {1'b1, 1'b1, we, a, 4'hF, d};
      do begin
         @(posedge clk);
         k++;
      end while (wb_rsp.ack !== 1'b1 && k < 20);
      rd = wb_rsp.dat;
      wb_req <= '0;
      if (k >= 20) begin
         error_cnt++;
         conclude();
      end
   endtask
   task automatic psave(input logic idle, input logic irq);
      @(posedge clk);
      save_exec <= 1'b1;
      save_idle <= idle;
      irq_pending <= irq;
      @(posedge clk);
      save_exec <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wdt_clear !== 1'b1 && n < 10);
      chk("wdt_clear", 1, n < 10);
   endtask
   task automatic wake(input int src);
      @(posedge clk);
      if (src == 0) irq_pending <= 1'b1;
      else wdt_timeout <= 1'b1;
      @(posedge clk);
      irq_pending <= 1'b0;
      wdt_timeout <= 1'b0;
      @(posedge clk);
      chk("cpu_clk_en", 1, cpu_clk_en);
      chk("sysosc_on", 1, sysosc_on);
   endtask
   task automatic count(input int len);
      cc = 0;
      pc = 0;
      repeat (len) begin
         @(posedge clk);
         cc += int'(cpu_clk_en === 1'b1);
         pc += int'(periph_clk_en === 1'b1);
      end
      chk("periph_ticks", len, pc);
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {arst_n, save_exec, save_idle, irq_pending, wdt_timeout} = '0;
      {pll_in_use, osc_dead} = '0;
      wb_req = '0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      chk("mod_clk_en", PCM_PRESENT, mod_clk_en);
      chk("low_power_rc_oscillator_on", 0, low_power_rc_oscillator_on);
      chk("trap", 0, clk_fail_trap);
      wb(0, PCM_ADDR_CLOCK_DIVIDER_REGISTER, 0);
      chk("divider", PCM_DIV_RESET, rd);
      wb(0, PCM_ADDR_GATE, 0);
      chk("gate", PCM_GATE_RESET, rd);
      foreach (rows[i]) begin
         wb(1, rows[i].adr, rows[i].wd);
         wb(0, rows[i].adr, 0);
         chk("readback", rows[i].exp, rd);
      end
      wb(1, PCM_ADDR_GATE, 32'h85);
      chk("mod_clk_en", PCM_PRESENT & ~8'hA0, mod_clk_en);
      repeat (4) @(posedge clk);
      chk("mod_clk_en", PCM_PRESENT & ~8'h85, mod_clk_en);
      wb(1, PCM_ADDR_GATE, 0);
      repeat (4) @(posedge clk);
      chk("mod_clk_en", PCM_PRESENT, mod_clk_en);
      for (int r = 0; r < 8; r++) begin
         wb(1, PCM_ADDR_CLOCK_DIVIDER_REGISTER, 32'h0800 | (r << 12));
         repeat (128) @(posedge clk);
         count(256);
         chk("cpu_ticks", 256 >> r, cc);
      end
      @(posedge clk);
      irq_pending <= 1'b1;
      wb(1, PCM_ADDR_CLOCK_DIVIDER_REGISTER, 32'hB800);
      repeat (16) @(posedge clk);
      count(32);
      chk("cpu_ticks", 32, cc);
      wb(1, PCM_ADDR_CLOCK_DIVIDER_REGISTER, 32'h3800);
      repeat (16) @(posedge clk);
      count(32);
      chk("cpu_ticks", 4, cc);
      irq_pending <= 1'b0;
      wb(1, PCM_ADDR_CLOCK_DIVIDER_REGISTER, 0);
      for (int s = 0; s < 2; s++) begin
         psave(0, 0);
         chk("sysosc_on", 0, sysosc_on);
         chk("periph_clk_en", 0, periph_clk_en);
         chk("mod_clk_en", 0, mod_clk_en);
         chk("low_power_rc_oscillator_on", 1, low_power_rc_oscillator_on);
         repeat (100) @(posedge clk);
         chk("trap", 0, clk_fail_trap);
         wake(s);
      end
      wb(1, PCM_ADDR_CFG, 1);
      repeat (100) @(posedge clk);
      chk("low_power_rc_oscillator_on", 1, low_power_rc_oscillator_on);
      chk("trap", 0, clk_fail_trap);
      psave(0, 0);
      chk("low_power_rc_oscillator_on", 0, low_power_rc_oscillator_on);
      wake(0);
      psave(1, 0);
      chk("cpu_clk_en", 0, cpu_clk_en);
      chk("periph_clk_en", 1, periph_clk_en);
      chk("mod_clk_en", PCM_PRESENT, mod_clk_en);
      chk("low_power_rc_oscillator_on", 1, low_power_rc_oscillator_on);
      wake(1);
      wb(1, PCM_ADDR_PSAVE, 1);
      repeat (2) @(posedge clk);
      chk("cpu_clk_en", 0, cpu_clk_en);
      chk("periph_clk_en", 1, periph_clk_en);
      wake(0);
      psave(0, 1);
      chk("sysosc_on", 0, sysosc_on);
      repeat (2) @(posedge clk);
      chk("cpu_clk_en", 1, cpu_clk_en);
      irq_pending <= 1'b0;
      pll_in_use <= 1'b1;
      osc_dead <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (clk_fail_trap !== 1'b1 && n < 300);
      chk("trap", 1, clk_fail_trap);
      chk("fallback_frc", 1, fallback_frc);
      chk("fallback_pll", 1, fallback_pll);
      wb(0, PCM_ADDR_STATUS, 0);
      chk("status_fail", 2'b11, rd[6:5]);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk("trap", 0, clk_fail_trap);
      arst_n <= 1'b1;
      wb(0, PCM_ADDR_CFG, 0);
      chk("cfg", 0, rd);
      conclude();
   end
endmodule // pcm_top_tb
